// File: inc/imuout_cfg.svh
// Constants for the IMU sample output path: map indices, field layout, timing.
// Assumes inclusion by imuout_pkg and the design files; definitions only.
`ifndef IMUOUT_CFG_SVH
`define IMUOUT_CFG_SVH

// Byte addresses of the data registers (acc 0..5, gyro 6..11)
`define IMUOUT_ADDR_ACC0   4'h0
`define IMUOUT_ADDR_ACC5   4'h5
`define IMUOUT_ADDR_GYR0   4'h6
`define IMUOUT_ADDR_GYR5   4'hb
`define IMUOUT_NUM_BYTES   12
// Config field positions within accel_config_reg / gyro_config_reg
`define IMUOUT_ODR_LSB     0
`define IMUOUT_ODR_MSB     3
`define IMUOUT_BWP_LSB     4
`define IMUOUT_BWP_MSB     6
`define IMUOUT_PERF_BIT    7
`define IMUOUT_BWP_NORMAL  3'h2
`define IMUOUT_CFG_RESET   8'ha8
// Accel odr codes: 0x1 = 0.78 Hz ... 0xc = 1600 Hz; 0x8 = 100 Hz
`define IMUOUT_ODR_MIN     4'h1
`define IMUOUT_ODR_LP_MIN  4'h1
`define IMUOUT_ODR_LP_MAX  4'ha
`define IMUOUT_ODR_HP_MIN  4'h5
`define IMUOUT_ODR_TOP     4'hc
// Base sample tick 1600 Hz, drdy pulse one 6400 Hz period
`define IMUOUT_CLK_HZ      100000000
`define IMUOUT_BASE_HZ     1600
`define IMUOUT_DRDY_HZ     6400
`define IMUOUT_TICK_CYC    (`IMUOUT_CLK_HZ / `IMUOUT_BASE_HZ)
`define IMUOUT_DRDY_CYC    (`IMUOUT_CLK_HZ / `IMUOUT_DRDY_HZ)

`endif

// File: inc/imuout_pkg.sv
// Types for the IMU sample output path.
// Assumes imuout_cfg.svh is on the include path.
`include "imuout_cfg.svh"
package imuout_pkg;
  typedef logic [7:0]  imuout_byte_t;
  typedef logic [15:0] imuout_word_t;
  typedef logic [3:0]  imuout_addr_t;
  typedef enum logic [1:0] {
    IMUOUT_IDLE,
    IMUOUT_ACQ,
    IMUOUT_EMIT
  } imuout_phase_t;
endpackage : imuout_pkg

// File: hdl/imuout_axis_lock.sv
// One axis of byte-wide sample readout with high-byte shadowing.
// Assumes read strobes are one-cycle pulses on sys_clk.
`timescale 1ns/10ps
module imuout_axis_lock
  import imuout_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire imuout_pkg::imuout_word_t sample,
  input  wire logic                     rd_low,
  input  wire logic                     rd_high,
  output      imuout_pkg::imuout_byte_t low_byte,
  output      imuout_pkg::imuout_byte_t high_byte
);
  logic         locked;
  imuout_byte_t shadow;

  // Low byte tracks the sample live; high byte shows the shadow once locked
  assign low_byte  = sample[7:0];
  assign high_byte = locked ? shadow : sample[15:8];

  // Lock on low read, release on high read so the next pair is fresh
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      locked <= 1'b0;
      shadow <= 8'h00;
    end else if (rd_low) begin
      locked <= 1'b1;
      shadow <= sample[15:8];
    end else if (rd_high) begin
      locked <= 1'b0;
    end
  end

  AST_LOCK_HOLDS:
  assert property (@(posedge sys_clk) disable iff (rst)
    rd_low && !rd_high ##1 !rd_low && !rd_high |-> high_byte == $past(sample[15:8], 1))
    else $error("high byte not frozen after low read");

  AST_RELEASE:
  assert property (@(posedge sys_clk) disable iff (rst)
    rd_high && !rd_low |=> high_byte == sample[15:8])
    else $error("high byte still locked after high read");
endmodule : imuout_axis_lock

// File: hdl/imuout_path.sv
// IMU sample output path: byte registers, rate engine, drdy flags.
// Assumes raw samples arrive synchronous to sys_clk as 1600 Hz strobes;
// host reads arrive as one-cycle strobes from the serial port logic.
//
// Behaviour
// - Accel axes: 16-bit two's complement, six bytes.
// - Low-byte read freezes paired accel high byte.
// - Gyro axes: 16-bit two's complement, six bytes.
// - Gyro low byte first; high byte then locked.
// - Perf bit set: equidistant accel, 12.5-1600 Hz.
// - Accel bandwidth field picks filter; 0x02 normal.
// - Normal accel cutoff scales with rate.
// - Normal accel group delay falls with rate.
// - Power save, no perf: duty-cycled idle/acquire.
// - Low power accel: ten rates, 0.78-400 Hz.
// - Average 2^bwp samples, skip remainder per cycle.
// - Drdy raised when full accel set written.
// - Unlatched drdy lasts one 6400 Hz period.
// - Status read clears interrupt drdy bit.
// - Any accel data read clears status drdy.
// - Drdy reaches pin only when mapped.
// - Gyro perf: equidistant 25 Hz to 3.2 kHz.
// - Gyro bandwidth field; 0x02 normal filter.
// - Normal gyro cutoff 11 to 751 Hz.
// - Normal gyro group delay 40 to 0.68 ms.
`timescale 1ns/10ps
`include "imuout_cfg.svh"
module imuout_path
  import imuout_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic [7:0]               accel_config_reg,
  input  wire logic [7:0]               gyro_config_reg,
  input  wire logic                     adv_power_save,
  input  wire logic                     accel_enable,
  input  wire logic                     gyro_enable,
  input  wire logic                     drdy_latched,
  input  wire logic                     drdy_map_int1,
  input  wire logic                     drdy_map_int2,
  input  wire logic                     raw_strobe,
  input  wire imuout_pkg::imuout_word_t raw_acc_x,
  input  wire imuout_pkg::imuout_word_t raw_acc_y,
  input  wire imuout_pkg::imuout_word_t raw_acc_z,
  input  wire imuout_pkg::imuout_word_t filt_gyr_x,
  input  wire imuout_pkg::imuout_word_t filt_gyr_y,
  input  wire imuout_pkg::imuout_word_t filt_gyr_z,
  input  wire logic                     gyr_strobe,
  input  wire logic                     rd_strobe,
  input  wire imuout_pkg::imuout_addr_t rd_addr,
  input  wire logic                     int_status_rd,
  output      imuout_pkg::imuout_byte_t rd_data,
  output      logic                     status_drdy_acc,
  output      logic                     int_status_drdy_acc,
  output      logic                     int1_out,
  output      logic                     int2_out,
  output      logic                     acc_low_power,
  output      logic                     acc_odr_valid
);
  localparam int TICK_CYC = `IMUOUT_TICK_CYC;
  localparam int DRDY_CYC = `IMUOUT_DRDY_CYC;

  // Configuration decode
  wire [3:0] acc_odr  = accel_config_reg[`IMUOUT_ODR_MSB:`IMUOUT_ODR_LSB];
  wire [2:0] acc_bwp  = accel_config_reg[`IMUOUT_BWP_MSB:`IMUOUT_BWP_LSB];
  wire       acc_perf = accel_config_reg[`IMUOUT_PERF_BIT];
  wire [3:0] gyr_odr  = gyro_config_reg[`IMUOUT_ODR_MSB:`IMUOUT_ODR_LSB];
  wire [2:0] gyr_bwp  = gyro_config_reg[`IMUOUT_BWP_MSB:`IMUOUT_BWP_LSB];
  wire       gyr_perf = gyro_config_reg[`IMUOUT_PERF_BIT];

  // Low power only with power save and perf bit clear; otherwise equidistant
  wire lp_mode = adv_power_save && !acc_perf;
  wire odr_ok_hp = acc_odr >= `IMUOUT_ODR_HP_MIN && acc_odr <= `IMUOUT_ODR_TOP;
  wire odr_ok_lp = acc_odr >= `IMUOUT_ODR_LP_MIN && acc_odr <= `IMUOUT_ODR_LP_MAX;
  wire odr_ok = lp_mode ? odr_ok_lp : odr_ok_hp;
  // Base samples per output period: 1600/ODR, a power of two per code step
  wire [3:0]  div_exp = `IMUOUT_ODR_TOP - acc_odr;
  wire [11:0] period  = odr_ok ? (12'h001 << div_exp) : 12'h001;
  // Averaging count 2^bwp, capped at the period so skip never goes negative
  wire [11:0] avg_raw = 12'h001 << acc_bwp;
  wire [11:0] avg_cnt = lp_mode ? ((avg_raw > period) ? period : avg_raw) : 12'h001;
  // Normal mode decimates; filter shaping by bwp is done upstream
  wire normal_filt = acc_bwp == `IMUOUT_BWP_NORMAL;
  wire gyr_normal  = gyr_bwp == `IMUOUT_BWP_NORMAL;
  wire gyr_run     = gyro_enable && gyr_perf && gyr_normal;

  assign acc_low_power = lp_mode;
  assign acc_odr_valid = odr_ok;

  // Base 1600 Hz tick from a divider; raw_strobe gives data, tick gives cadence
  // Sixteen bits: the tick count exceeds what fourteen bits can hold
  logic [15:0] tick_cnt;
  wire tick = tick_cnt == 16'(TICK_CYC - 1);
  always_ff @(posedge sys_clk) begin
    if (rst || tick) tick_cnt <= 16'h0000;
    else             tick_cnt <= tick_cnt + 16'h0001;
  end

  // Duty cycle: acquire avg_cnt samples, then idle for the rest of period
  imuout_phase_t phase;
  logic [11:0]   slot;
  logic [11:0]   taken;
  logic [19:0]   sum_x, sum_y, sum_z;
  wire take   = (phase == IMUOUT_ACQ) && raw_strobe;
  wire last_t = take && (taken + 12'h001 == avg_cnt);
  wire slot_end = tick && (slot + 12'h001 >= period);
  // Arithmetic shift by bwp gives the mean of 2^bwp samples when avg_cnt is not capped at period
  wire [3:0] sh = lp_mode ? 4'(acc_bwp) : 4'h0;
  wire signed [19:0] nx = $signed(sum_x + {{4{raw_acc_x[15]}}, raw_acc_x}) >>> sh;
  wire signed [19:0] ny = $signed(sum_y + {{4{raw_acc_y[15]}}, raw_acc_y}) >>> sh;
  wire signed [19:0] nz = $signed(sum_z + {{4{raw_acc_z[15]}}, raw_acc_z}) >>> sh;

  imuout_word_t acc_x, acc_y, acc_z;
  logic         acc_new;

  // Sequencer: one output per period, equidistant when avg_cnt is one
  always_ff @(posedge sys_clk) begin
    if (rst || !accel_enable || !odr_ok) begin
      phase <= IMUOUT_IDLE;
      slot  <= 12'h000;
      taken <= 12'h000;
    end else begin
      unique case (phase)
        IMUOUT_IDLE: begin
          if (tick) begin
            phase <= IMUOUT_ACQ;
            slot  <= 12'h000;
            taken <= 12'h000;
          end
        end
        IMUOUT_ACQ: begin
          if (last_t) phase <= IMUOUT_EMIT;
          if (take)   taken <= taken + 12'h001;
          if (tick)   slot  <= slot + 12'h001;
        end
        IMUOUT_EMIT: begin
          // Skipped samples: wait out the remaining base slots
          if (slot_end) begin
            phase <= IMUOUT_ACQ;
            slot  <= 12'h000;
            taken <= 12'h000;
          end else if (tick) begin
            slot  <= slot + 12'h001;
          end
        end
        default: phase <= IMUOUT_IDLE;
      endcase
    end
  end

  // Accumulators clear when an output is emitted
  always_ff @(posedge sys_clk) begin
    if (rst || last_t || phase != IMUOUT_ACQ) begin
      sum_x <= 20'h00000;
      sum_y <= 20'h00000;
      sum_z <= 20'h00000;
    end else if (take) begin
      sum_x <= sum_x + {{4{raw_acc_x[15]}}, raw_acc_x};
      sum_y <= sum_y + {{4{raw_acc_y[15]}}, raw_acc_y};
      sum_z <= sum_z + {{4{raw_acc_z[15]}}, raw_acc_z};
    end
  end

  // Full three-axis set lands in one edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_x   <= 16'h0000;
      acc_y   <= 16'h0000;
      acc_z   <= 16'h0000;
      acc_new <= 1'b0;
    end else begin
      acc_new <= last_t;
      if (last_t) begin
        acc_x <= nx[15:0];
        acc_y <= ny[15:0];
        acc_z <= nz[15:0];
      end
    end
  end

  // Gyro data registers updated on filtered strobe when enabled, in perf mode with bwp 0x02 normal
  imuout_word_t gyr_x, gyr_y, gyr_z;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gyr_x <= 16'h0000;
      gyr_y <= 16'h0000;
      gyr_z <= 16'h0000;
    end else if (gyr_strobe && gyr_run) begin
      gyr_x <= filt_gyr_x;
      gyr_y <= filt_gyr_y;
      gyr_z <= filt_gyr_z;
    end
  end

  // Read decode: even address is the low byte of its axis
  wire rd_acc = rd_strobe && rd_addr <= `IMUOUT_ADDR_ACC5;
  wire rd_gyr = rd_strobe && rd_addr >= `IMUOUT_ADDR_GYR0 && rd_addr <= `IMUOUT_ADDR_GYR5;
  imuout_word_t axis_word [6];
  imuout_byte_t axis_lo   [6];
  imuout_byte_t axis_hi   [6];
  assign axis_word[0] = acc_x;
  assign axis_word[1] = acc_y;
  assign axis_word[2] = acc_z;
  assign axis_word[3] = gyr_x;
  assign axis_word[4] = gyr_y;
  assign axis_word[5] = gyr_z;

  // Relies on the host reading low before high for coherent pairs
  for (genvar a = 0; a < 6; a++) begin : g_axis
    wire lo_hit = rd_strobe && rd_addr == 4'(2 * a);
    wire hi_hit = rd_strobe && rd_addr == 4'(2 * a + 1);
    imuout_axis_lock u_lock (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .sample    (axis_word[a]),
      .rd_low    (lo_hit),
      .rd_high   (hi_hit),
      .low_byte  (axis_lo[a]),
      .high_byte (axis_hi[a])
    );
  end

  // Registered read data; unmapped addresses read zero
  wire [2:0]    rd_axis = 3'(rd_addr >> 1);
  wire          rd_hit  = rd_addr <= `IMUOUT_ADDR_GYR5;
  imuout_byte_t next_rd_data;
  assign next_rd_data = !rd_hit ? 8'h00 :
                        rd_addr[0] ? axis_hi[rd_axis] : axis_lo[rd_axis];
  always_ff @(posedge sys_clk) begin
    if (rst)            rd_data <= 8'h00;
    else if (rd_strobe) rd_data <= next_rd_data;
  end

  // Status flags: new data sets wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_drdy_acc     <= 1'b0;
      int_status_drdy_acc <= 1'b0;
    end else begin
      if (acc_new)           status_drdy_acc     <= 1'b1;
      else if (rd_acc)       status_drdy_acc     <= 1'b0;
      if (acc_new)           int_status_drdy_acc <= 1'b1;
      else if (int_status_rd) int_status_drdy_acc <= 1'b0;
    end
  end

  // Interrupt line: timed pulse unlatched, else follows the interrupt status flag
  logic [13:0] pulse_cnt;
  wire         drdy_line = drdy_latched ? int_status_drdy_acc : (pulse_cnt != 14'h0000);
  always_ff @(posedge sys_clk) begin
    if (rst)                    pulse_cnt <= 14'h0000;
    else if (acc_new)           pulse_cnt <= 14'(DRDY_CYC);
    else if (pulse_cnt != 14'h0000) pulse_cnt <= pulse_cnt - 14'h0001;
  end

  // Mapping gates the line onto each pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      int1_out <= 1'b0;
      int2_out <= 1'b0;
    end else begin
      int1_out <= drdy_line && drdy_map_int1;
      int2_out <= drdy_line && drdy_map_int2;
    end
  end

  AST_DRDY_SET:
  assert property (@(posedge sys_clk) disable iff (rst)
    acc_new |=> status_drdy_acc && int_status_drdy_acc)
    else $error("drdy flags not set after new sample set");

  AST_STATUS_CLR:
  assert property (@(posedge sys_clk) disable iff (rst)
    rd_acc && !acc_new |=> !status_drdy_acc)
    else $error("status drdy not cleared by data read");

  AST_INT_CLR:
  assert property (@(posedge sys_clk) disable iff (rst)
    int_status_rd && !acc_new |=> !int_status_drdy_acc)
    else $error("interrupt drdy not cleared by status read");

  AST_PULSE_LEN:
  assert property (@(posedge sys_clk) disable iff (rst)
    acc_new |=> pulse_cnt == 14'(DRDY_CYC))
    else $error("drdy pulse length wrong");

  AST_UNMAPPED:
  assert property (@(posedge sys_clk) disable iff (rst)
    !$past(drdy_map_int1) |-> !int1_out)
    else $error("int1 asserted while not mapped");

  AST_LP_ODR:
  assert property (@(posedge sys_clk) disable iff (rst)
    lp_mode && acc_odr > `IMUOUT_ODR_LP_MAX |-> !acc_odr_valid)
    else $error("low power accepted rate above 400 Hz");

  AST_AVG_CAP:
  assert property (@(posedge sys_clk) disable iff (rst)
    phase == IMUOUT_ACQ |-> taken < avg_cnt)
    else $error("more samples averaged than configured");

  AST_HP_ONE:
  assert property (@(posedge sys_clk) disable iff (rst)
    !lp_mode |-> avg_cnt == 12'h001)
    else $error("equidistant mode must not average");
endmodule : imuout_path

// File: bench/imuout_host_model.sv
// Host-side model: byte reads and interrupt status reads over strobe ports.
// Assumes the path answers rd_data on the same edge that samples rd_strobe.
`timescale 1ns/10ps
module imuout_host_model
  import imuout_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire imuout_pkg::imuout_byte_t rd_data,
  output      logic                     rd_strobe,
  output      imuout_pkg::imuout_addr_t rd_addr,
  output      logic                     int_status_rd
);
  // Idle bus parks on an unmapped address
  initial begin
    rd_strobe     = 1'b0;
    rd_addr       = 4'hf;
    int_status_rd = 1'b0;
  end

  // One byte read; data taken at the edge that answers
  task automatic read_byte(input imuout_addr_t a, output imuout_byte_t d);
    @(posedge sys_clk);
    rd_strobe <= 1'b1;
    rd_addr   <= a;
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
    rd_addr   <= ~a; // Released address must not look like a stale request
    #1 d = rd_data;
  endtask : read_byte

  // Low byte always first so the high byte is shadowed
  task automatic read_word(input imuout_addr_t lo_a, output imuout_word_t w);
    imuout_byte_t lo;
    imuout_byte_t hi;
    read_byte(lo_a, lo);
    read_byte(lo_a + 4'h1, hi);
    w = {hi, lo};
  endtask : read_word

  // Interrupt status read, one-cycle pulse
  task automatic status_read();
    @(posedge sys_clk);
    int_status_rd <= 1'b1;
    @(posedge sys_clk);
    int_status_rd <= 1'b0;
  endtask : status_read

  // Cross-axis fix of X; factor is a 7-bit signed value
  function automatic imuout_word_t cross_fix(input imuout_word_t x, input imuout_word_t z,
                                             input logic [6:0] f);
    logic signed [31:0] prod;
    prod = $signed({{9{f[6]}}, f}) * $signed(z);
    return x - imuout_word_t'(prod >>> 9);
  endfunction : cross_fix
endmodule : imuout_host_model

// File: bench/imu_sample_output_path_tb.sv
// Self-checking bench for the IMU sample output path.
// Assumes imuout_cfg.svh on the include path; host model drives the read ports.
`timescale 1ns/10ps
`include "imuout_cfg.svh"
`define IMUOUT_CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
      n_errors++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
  end
module imu_sample_output_path_tb;
  import imuout_pkg::*;
  localparam logic [7:0] CFG_T [7] = '{8'h21, 8'h2a, 8'h2b, 8'ha5, 8'ha4, 8'hac, 8'had};
  localparam logic [6:0] ADV_T = 7'b1000111;
  localparam logic [6:0] LP_T  = 7'b0000111;
  localparam logic [6:0] OK_T  = 7'b0101011;
  logic         sys_clk, rst, adv_power_save, accel_enable, gyro_enable;
  logic         drdy_latched, drdy_map_int1, drdy_map_int2, raw_strobe, gyr_strobe;
  logic [7:0]   accel_config_reg, gyro_config_reg;
  imuout_word_t raw_acc_x, raw_acc_y, raw_acc_z, filt_gyr_x, filt_gyr_y, filt_gyr_z;
  logic         rd_strobe, int_status_rd, status_drdy_acc, int_status_drdy_acc;
  logic         int1_out, int2_out, acc_low_power, acc_odr_valid;
  imuout_addr_t rd_addr;
  imuout_byte_t rd_data;
  int           n_errors = 0;
  int           cmp_count = 0;

  imuout_path u_imuout_path (.sys_clk(sys_clk), .rst(rst), .accel_config_reg(accel_config_reg),
    .gyro_config_reg(gyro_config_reg), .adv_power_save(adv_power_save),
    .accel_enable(accel_enable), .gyro_enable(gyro_enable), .drdy_latched(drdy_latched),
    .drdy_map_int1(drdy_map_int1), .drdy_map_int2(drdy_map_int2), .raw_strobe(raw_strobe),
    .raw_acc_x(raw_acc_x), .raw_acc_y(raw_acc_y), .raw_acc_z(raw_acc_z),
    .filt_gyr_x(filt_gyr_x), .filt_gyr_y(filt_gyr_y), .filt_gyr_z(filt_gyr_z),
    .gyr_strobe(gyr_strobe), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
    .int_status_rd(int_status_rd), .rd_data(rd_data), .status_drdy_acc(status_drdy_acc),
    .int_status_drdy_acc(int_status_drdy_acc), .int1_out(int1_out), .int2_out(int2_out),
    .acc_low_power(acc_low_power), .acc_odr_valid(acc_odr_valid));

  imuout_host_model u_imuout_host_model (.sys_clk(sys_clk), .rd_data(rd_data),
    .rd_strobe(rd_strobe), .rd_addr(rd_addr), .int_status_rd(int_status_rd));

  // Free-running 100 MHz clock
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  task automatic final_report();
    $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // Gyro sample strobe; data lands on the edge that samples it, then two idle cycles
  task automatic push_gyro(input imuout_word_t x, input imuout_word_t y, input imuout_word_t z);
    @(posedge sys_clk);
    filt_gyr_x <= x;
    filt_gyr_y <= y;
    filt_gyr_z <= z;
    gyr_strobe <= 1'b1;
    @(posedge sys_clk);
    gyr_strobe <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : push_gyro

  // Mode and rate validity decode over a table of settings
  task automatic t_mode_decode();
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      adv_power_save   <= ADV_T[i];
      accel_config_reg <= CFG_T[i];
      #1;
      `IMUOUT_CHK("acc_low_power", LP_T[i], acc_low_power)
      `IMUOUT_CHK("acc_odr_valid", OK_T[i], acc_odr_valid)
    end
  endtask : t_mode_decode

  // Gyro words, shadowed high byte and release after the high read
  task automatic t_gyro_lock();
    imuout_word_t w [3];
    imuout_byte_t b;
    push_gyro(16'h0100, 16'h8001, 16'h0200);
    for (int i = 0; i < 3; i++) u_imuout_host_model.read_word(4'h6 + 4'(2 * i), w[i]);
    `IMUOUT_CHK("gyro_x", 16'h0100, w[0])
    `IMUOUT_CHK("gyro_y", 16'h8001, w[1])
    `IMUOUT_CHK("gyro_z", 16'h0200, w[2])
    `IMUOUT_CHK("x_fixed", 16'h0101, u_imuout_host_model.cross_fix(w[0], w[2], 7'h7f))
    u_imuout_host_model.read_byte(4'h6, b);
    push_gyro(16'h5aa5, 16'h1234, 16'h4321);
    u_imuout_host_model.read_byte(4'h7, b);
    `IMUOUT_CHK("gyro_x_high_locked", 8'h01, b)
    u_imuout_host_model.read_byte(4'h7, b);
    `IMUOUT_CHK("gyro_x_high_live", 8'h5a, b)
    u_imuout_host_model.read_byte(4'hc, b);
    `IMUOUT_CHK("unmapped_read", 8'h00, b)
  endtask : t_gyro_lock

  // One accel sample: drdy pulse width, pin mapping, flag clearing
  task automatic t_accel_sample();
    int           n;
    int           hi2;
    imuout_word_t w [3];
    imuout_byte_t b;
    @(posedge sys_clk);
    adv_power_save   <= 1'b0;
    accel_config_reg <= 8'hac;
    raw_acc_x        <= 16'hfe12;
    raw_acc_y        <= 16'h7f34;
    raw_acc_z        <= 16'h8056;
    raw_strobe       <= 1'b1;
    n = 0;
    // Bounded wait: one 1600 Hz tick plus margin
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (status_drdy_acc !== 1'b1 && n < 70000);
    if (n >= 70000) begin
      n_errors++;
      final_report();
    end
    raw_strobe <= 1'b0;
    `IMUOUT_CHK("int_status_drdy", 1'b1, int_status_drdy_acc)
    @(posedge sys_clk);
    #1;
    `IMUOUT_CHK("int1_rise", 1'b1, int1_out)
    n   = 1;
    hi2 = 0;
    while (int1_out === 1'b1 && n < 20000) begin
      @(posedge sys_clk);
      #1;
      if (int1_out === 1'b1) n++;
      if (int2_out !== 1'b0) hi2++;
    end
    if (n >= 20000) begin
      n_errors++;
      final_report();
    end
    `IMUOUT_CHK("int1_width", `IMUOUT_DRDY_CYC, n)
    `IMUOUT_CHK("int2_unmapped", 0, hi2)
    u_imuout_host_model.read_byte(4'h6, b);
    `IMUOUT_CHK("status_after_gyro_read", 1'b1, status_drdy_acc)
    for (int i = 0; i < 3; i++) u_imuout_host_model.read_word(4'(2 * i), w[i]);
    `IMUOUT_CHK("status_after_acc_read", 1'b0, status_drdy_acc)
    `IMUOUT_CHK("acc_x", 16'hfe12, w[0])
    `IMUOUT_CHK("acc_y", 16'h7f34, w[1])
    `IMUOUT_CHK("acc_z", 16'h8056, w[2])
    `IMUOUT_CHK("int_status_kept", 1'b1, int_status_drdy_acc)
    // Latched line follows the interrupt flag; map moved to int2 only
    @(posedge sys_clk);
    drdy_latched  <= 1'b1;
    drdy_map_int1 <= 1'b0;
    drdy_map_int2 <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    `IMUOUT_CHK("int1_unmapped", 1'b0, int1_out)
    `IMUOUT_CHK("int2_latched", 1'b1, int2_out)
    u_imuout_host_model.status_read();
    #1;
    `IMUOUT_CHK("int_status_cleared", 1'b0, int_status_drdy_acc)
    @(posedge sys_clk);
    #1;
    `IMUOUT_CHK("int2_latched_clear", 1'b0, int2_out)
  endtask : t_accel_sample

  // Main sequence: reset, then each scenario in turn
  initial begin
    rst = 1'b1;
    accel_config_reg = 8'ha8;
    gyro_config_reg = 8'ha8;
    {adv_power_save, drdy_latched, drdy_map_int2, raw_strobe, gyr_strobe} = '0;
    {accel_enable, gyro_enable, drdy_map_int1} = 3'b111;
    {raw_acc_x, raw_acc_y, raw_acc_z} = '0;
    {filt_gyr_x, filt_gyr_y, filt_gyr_z} = '0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    `IMUOUT_CHK("rd_data_reset", 8'h00, rd_data)
    `IMUOUT_CHK("flags_reset", 4'h0, {status_drdy_acc, int_status_drdy_acc, int1_out, int2_out})
    t_mode_decode();
    t_gyro_lock();
    t_accel_sample();
    final_report();
  end
endmodule : imu_sample_output_path_tb
